//--- bench/step_controller.sv
/*
 * Model of the external controller that drives the step-select pin.
 * Assumes its tasks are called at a falling edge of clk and that clk runs freely.
 */
`timescale 1ns/1ps
`default_nettype none

module step_controller (
    input  wire logic clk,      // System clock.
    output var logic  step_pin  // Step-select pin.
);
    initial step_pin = 1'b0;

    // High for hi cycles, then low for lo cycles; every change lands on a falling edge.
    task automatic pulse(input int hi, input int lo);
        step_pin = 1'b1;
        repeat (hi) @(negedge clk);
        step_pin = 1'b0;
        repeat (lo) @(negedge clk);
    endtask

    // One arming pulse, then the quiet gap that must precede the first step.
    task automatic arm(input int gap);
        pulse(6, gap);
    endtask
endmodule

`default_nettype wire

//--- bench/tb.sv
/*
 * Self-checking bench for the monitor multiplexer sequencer.
 * Assumes the design package and timing header are compiled or on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mon_consts.svh"

module tb;
    import mon_pkg::*;
    localparam int GAP  = (`ARM_GAP_MIN_CYC + `ARM_GAP_MAX_CYC) / 2;
    localparam int IDLE = `IDLE_RESET_CYC + 50;
    localparam int GAP_SHORT = `ARM_GAP_MIN_CYC / 2;
    localparam int GAP_LONG  = `ARM_GAP_MAX_CYC + 100;

    logic      clk = 1'b0;
    logic      rst;
    wire logic step_pin;
    level_t    en_lvl;
    level_t    role;
    logic [3:0] sense;
    logic      bypass_n;
    logic      supply;
    step_select_t  mux;
    logic      flag_o;
    logic      flag_oe;
    logic      ground;
    int        num_errors;
    int        checked;
    int        seed;

    always #12.5 clk = ~clk;

    step_controller ctl_u (.clk(clk), .step_pin(step_pin));

    monitor_mux_sequencer dut_u (
        .CLK(clk), .RST(rst), .STEP_SELECT(step_pin), .ENABLE_LEVEL(en_lvl),
        .ROLE_LEVEL(role), .BUS_SENSE_ABOVE_REF(sense), .BUS_CHECK_BYPASS_N(bypass_n),
        .SUPPLY_OK(supply), .MUX_SELECT(mux), .BUS_VALID_FLAG_O(flag_o),
        .BUS_VALID_FLAG_OE(flag_oe), .DIVIDER_GROUND_SWITCH(ground));

    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic step_select_t exp_mux(input level_t r, input int s);
        step_select_t m;
        int       idx;
        m = '0;
        idx = (r == LVL_HIGH) ? s - 7 : s - 1;
        m.drive = (r == LVL_FLOAT) || (r == LVL_LOW && s <= 6) || (r == LVL_HIGH && s >= 7);
        if (m.drive) begin
            m.channel = idx[2:1];
            m.shunt = idx[0];
        end
        return m;
    endfunction

    // Compares the whole selector while driving; when released only drive is defined.
    task automatic check_step(input level_t r, input int s);
        step_select_t e;
        e = exp_mux(r, s);
        if (e.drive)
            check("mux_select", mux, e);
        else
            check("mux_drive", {3'h0, mux.drive}, 4'h0);
    endtask

    task automatic run_role(input level_t r);
        int n;
        n = (r == LVL_FLOAT) ? `STEPS_ALONE : `STEPS_PAIRED;
        role = r;
        ctl_u.arm(GAP);
        for (int k = 0; k < n + 2; k++) begin
            ctl_u.pulse(6, 6);
            check_step(r, (k % n) + 1);
        end
        repeat (IDLE) @(negedge clk);
        check("idle_low_drive", {3'h0, mux.drive}, 4'h0);
    endtask

    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #(40000 * 25);
        num_errors++;
        final_report();
    end

    initial begin
        seed = 32'h04fd;
        num_errors = 0;
        checked = 0;
        rst = 1'b1;
        en_lvl = LVL_LOW;
        role = LVL_FLOAT;
        sense = 4'hf;
        bypass_n = 1'b1;
        supply = 1'b0;
        repeat (10) @(negedge clk);
        check("reset_mux", mux, 4'h0);
        check("reset_flag_oe", {3'h0, flag_oe}, 4'h1);
        check("reset_ground", {3'h0, ground}, 4'h0);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check("ramp_flag_oe", {3'h0, flag_oe}, 4'h1);
        // The supply comes up with enable still low; only then may the flag be released.
        supply = 1'b1;
        repeat (4) @(negedge clk);
        check("powered_flag_oe", {3'h0, flag_oe}, 4'h0);
        run_role(LVL_FLOAT);
        run_role(LVL_LOW);
        run_role(LVL_HIGH);
        // After a timeout a gap too short or too long must be refused and re-arm instead.
        role = LVL_FLOAT;
        ctl_u.pulse(6, GAP_SHORT);
        ctl_u.pulse(6, GAP_LONG);
        check("short_gap_drive", {3'h0, mux.drive}, 4'h0);
        ctl_u.pulse(6, GAP);
        check("rearm_drive", {3'h0, mux.drive}, 4'h0);
        ctl_u.pulse(6, 6);
        check("restart_step", mux, 4'h8);
        ctl_u.pulse(IDLE, 6);
        check("idle_high_drive", {3'h0, mux.drive}, 4'h0);
        // Enable leaving LOW mid-run resets the stepper and drops the output.
        ctl_u.arm(GAP);
        ctl_u.pulse(6, 6);
        check("run_step", mux, 4'h8);
        // A reset in mid-run drops the output at once; stepping needs a fresh arming.
        rst = 1'b1;
        @(negedge clk);
        check("mid_reset_mux", mux, 4'h0);
        rst = 1'b0;
        ctl_u.pulse(6, GAP);
        check("mid_reset_drive", {3'h0, mux.drive}, 4'h0);
        ctl_u.pulse(6, 6);
        check("mid_reset_step", mux, 4'h8);
        en_lvl = LVL_FLOAT;
        repeat (6) @(negedge clk);
        check("float_drive", {3'h0, mux.drive}, 4'h0);
        check("float_ground", {3'h0, ground}, 4'h1);
        en_lvl = LVL_HIGH;
        repeat (6) @(negedge clk);
        check("high_ground", {3'h0, ground}, 4'h0);
        en_lvl = LVL_LOW;
        repeat (6) @(negedge clk);
        ctl_u.pulse(6, 6);
        check("after_enable_drive", {3'h0, mux.drive}, 4'h0);
        // Random bus-valid and enable conditions.
        for (int i = 0; i < 60; i++) begin
            sense = 4'($random(seed));
            if (i % 3 == 0)
                sense = 4'hf;
            bypass_n = 1'($random(seed));
            supply = ($random(seed) & 7) != 0;
            en_lvl = level_t'(2'(($random(seed) & 32'h7fff) % 3));
            repeat (5) @(negedge clk);
            check("flag_oe", {3'h0, flag_oe},
                  {3'h0, !(supply && en_lvl != LVL_HIGH && (!bypass_n || &sense))});
            check("flag_o", {3'h0, flag_o}, 4'h0);
            check("ground", {3'h0, ground}, {3'h0, en_lvl != LVL_HIGH});
        end
        final_report();
    end
endmodule

`default_nettype wire

//--- hw/mon_consts.svh
/*
 * Timing counts, step limits and synchroniser width for the monitor multiplexer sequencer.
 * Assumes a 40 MHz system clock; every cycle count is derived from a time in ns.
 */
`ifndef MON_CONSTS_SVH
`define MON_CONSTS_SVH

`define CLK_MHZ            40
`define ARM_GAP_MIN_NS     14750
`define ARM_GAP_MAX_NS     24250
`define IDLE_RESET_NS      35000

// A least time rounds up, a longest time rounds down.
`define ARM_GAP_MIN_CYC    ((`ARM_GAP_MIN_NS * `CLK_MHZ + 999) / 1000)
`define ARM_GAP_MAX_CYC    ((`ARM_GAP_MAX_NS * `CLK_MHZ) / 1000)
`define IDLE_RESET_CYC     ((`IDLE_RESET_NS * `CLK_MHZ + 999) / 1000)

`define STEPS_ALONE        8
`define STEPS_PAIRED       12
`define STEPS_PER_DEVICE   6

`define SYNC_WIDTH         11

`endif

//--- hw/mon_pkg.sv
/*
 * Types shared by the monitor multiplexer sequencer files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mon_pkg;

    // Three-level pins arrive already resolved by the pad comparators.
    typedef enum logic [1:0] {
        LVL_LOW   = 2'b00,
        LVL_FLOAT = 2'b01,
        LVL_HIGH  = 2'b10
    } level_t;

    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_ARMING  = 2'b01,
        ST_GAP     = 2'b11,
        ST_RUN     = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic       drive;    // Differential output actively driven.
        logic [1:0] channel;  // Channel 0..3 of this device.
        logic       shunt;    // 1 = shunt current, 0 = bus voltage.
    } step_select_t;

endpackage

//--- hw/monitor_mux_sequencer.sv
/*
 * Step sequencer, bus-valid gating and divider ground switch of a four-channel
 * bus voltage and shunt current monitor.
 * Assumes the pads resolve the three-level pins to two-bit codes and that the
 * analog comparators deliver one level per bus sense input; all pins are async.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mon_consts.svh"

module monitor_mux_sequencer (
    input  wire logic           CLK,                    // 40 MHz clock.
    input  wire logic           RST,                    // Async reset, active high.
    input  wire logic           STEP_SELECT,            // Step-select pin.
    input  wire mon_pkg::level_t ENABLE_LEVEL,          // Enable pin level code.
    input  wire mon_pkg::level_t ROLE_LEVEL,            // Pairing-role pin level code.
    input  wire logic [3:0]     BUS_SENSE_ABOVE_REF,    // Bus sense input above threshold.
    input  wire logic           BUS_CHECK_BYPASS_N,     // Low ignores the bus sense inputs.
    input  wire logic           SUPPLY_OK,              // Main supply above its threshold.
    output mon_pkg::step_select_t   MUX_SELECT,             // Multiplexer position and drive.
    output logic                BUS_VALID_FLAG_O,       // Open-drain data, always low.
    output logic                BUS_VALID_FLAG_OE,      // High pulls the flag low.
    output logic                DIVIDER_GROUND_SWITCH   // High closes the divider ground.
);
    import mon_pkg::*;

    localparam logic [10:0] RESET_CYC = 11'(`IDLE_RESET_CYC);
    localparam logic [9:0]  GAP_MIN   = 10'(`ARM_GAP_MIN_CYC);
    localparam logic [9:0]  GAP_MAX   = 10'(`ARM_GAP_MAX_CYC);
    localparam logic [3:0]  LAST_ALONE  = 4'(`STEPS_ALONE);
    localparam logic [3:0]  LAST_PAIRED = 4'(`STEPS_PAIRED);
    localparam logic [3:0]  HALF_STEPS  = 4'(`STEPS_PER_DEVICE);

    logic [`SYNC_WIDTH-1:0] sync_q;
    logic                   s_step;
    level_t                 s_en;
    level_t                 s_role;
    logic [3:0]             s_above;
    logic                   s_check;
    logic                   s_sup;

    pin_sync #(.WIDTH(`SYNC_WIDTH)) u_sync (
        .clk   (CLK),
        .rst   (RST),
        .d_in  ({STEP_SELECT, ENABLE_LEVEL, ROLE_LEVEL, BUS_SENSE_ABOVE_REF,
                 BUS_CHECK_BYPASS_N, SUPPLY_OK}),
        .q_out (sync_q)
    );

    assign s_step  = sync_q[10];
    assign s_en    = level_t'(sync_q[9:8]);
    assign s_role  = level_t'(sync_q[7:6]);
    assign s_above = sync_q[5:2];
    assign s_check = sync_q[1];
    assign s_sup   = sync_q[0];

    seq_state_t state_reg, state_next;
    logic [3:0]  step_reg, step_next;
    logic [10:0] idle_cnt_reg, idle_cnt_next;
    logic [9:0]  gap_cnt_reg, gap_cnt_next;
    logic        step_d_reg;
    level_t      role_reg;
    step_select_t    mux_reg, mux_next;
    logic        flag_oe_reg, flag_oe_next;
    logic        gnd_sw_reg, gnd_sw_next;

    logic        step_rise;
    logic        step_fall;
    logic        timeout;
    logic        en_full;
    logic        paired;
    logic [3:0]  last_step;
    logic [3:0]  idx;

    assign step_rise = s_step & ~step_d_reg;
    assign step_fall = ~s_step & step_d_reg;
    assign timeout   = (idle_cnt_reg >= RESET_CYC);
    assign en_full   = (s_en == LVL_LOW);
    assign paired    = (s_role != LVL_FLOAT);
    assign last_step = paired ? LAST_PAIRED : LAST_ALONE;

    always_comb begin
        state_next    = state_reg;
        step_next     = step_reg;
        gap_cnt_next  = gap_cnt_reg;
        idx           = 4'h0;
        mux_next      = '0;
        // Any edge restarts the static-level timer; it saturates so a long idle never wraps.
        if (step_rise | step_fall) begin
            idle_cnt_next = 11'h000;
        end else if (timeout) begin
            idle_cnt_next = idle_cnt_reg;
        end else begin
            idle_cnt_next = idle_cnt_reg + 11'h001;
        end
        case (state_reg)
            ST_STANDBY: begin
                step_next = 4'h0;
                if (step_rise) begin
                    state_next = ST_ARMING;
                end
            end
            ST_ARMING: begin
                if (step_fall) begin
                    state_next   = ST_GAP;
                    gap_cnt_next = 10'h000;
                end
            end
            ST_GAP: begin
                if (gap_cnt_reg != GAP_MAX + 10'h001) begin
                    gap_cnt_next = gap_cnt_reg + 10'h001;
                end
                // A rise outside the gap window is taken as one more arming pulse.
                if (step_rise) begin
                    if (gap_cnt_reg >= GAP_MIN && gap_cnt_reg <= GAP_MAX) begin
                        state_next = ST_RUN;
                        step_next  = 4'h1;
                    end else begin
                        state_next = ST_ARMING;
                    end
                end
            end
            ST_RUN: begin
                if (step_rise) begin
                    step_next = (step_reg >= last_step) ? 4'h1 : step_reg + 4'h1;
                end
            end
            default: begin
                state_next = ST_STANDBY;
                step_next  = 4'h0;
            end
        endcase
        if ((timeout && state_reg != ST_STANDBY) || !en_full) begin
            state_next = ST_STANDBY;
            step_next  = 4'h0;
        end
        if (state_next == ST_RUN) begin
            if (s_role == LVL_HIGH) begin
                idx           = step_next - HALF_STEPS - 4'h1;
                mux_next.drive = (step_next > HALF_STEPS);
            end else if (s_role == LVL_LOW) begin
                idx           = step_next - 4'h1;
                mux_next.drive = (step_next <= HALF_STEPS);
            end else begin
                idx           = step_next - 4'h1;
                mux_next.drive = 1'b1;
            end
            mux_next.channel = idx[2:1];
            mux_next.shunt   = idx[0];
        end
        // The flag is released only when powered, enabled and every input is valid or the bus check is bypassed.
        flag_oe_next = !(s_sup && s_en != LVL_HIGH && (!s_check || (&s_above)));
        gnd_sw_next  = (s_en != LVL_HIGH);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg    <= ST_STANDBY;
            step_reg     <= 4'h0;
            idle_cnt_reg <= 11'h000;
            gap_cnt_reg  <= 10'h000;
            step_d_reg   <= 1'b0;
            role_reg     <= LVL_FLOAT;
            mux_reg      <= '0;
            flag_oe_reg  <= 1'b1;
            gnd_sw_reg   <= 1'b0;
        end else begin
            state_reg    <= state_next;
            step_reg     <= step_next;
            idle_cnt_reg <= idle_cnt_next;
            gap_cnt_reg  <= gap_cnt_next;
            step_d_reg   <= s_step;
            role_reg     <= s_role;
            mux_reg      <= mux_next;
            flag_oe_reg  <= flag_oe_next;
            gnd_sw_reg   <= gnd_sw_next;
        end
    end

    assign MUX_SELECT            = mux_reg;
    assign BUS_VALID_FLAG_OE     = flag_oe_reg;
    assign DIVIDER_GROUND_SWITCH = gnd_sw_reg;
    assign BUS_VALID_FLAG_O      = 1'b0;

    property p_step_advance;
        @(posedge CLK) disable iff (RST)
        (state_reg == ST_RUN && step_rise && !timeout && en_full && step_reg < 4'h8)
        |=> (step_reg == $past(step_reg) + 4'h1);
    endproperty
    a_step_advance: assert property (p_step_advance) else $error("step did not advance");

    property p_alone_map;
        @(posedge CLK) disable iff (RST)
        (state_reg == ST_RUN && role_reg == LVL_FLOAT)
        |-> (mux_reg.drive && {1'b0, mux_reg.channel, mux_reg.shunt} == step_reg - 4'h1);
    endproperty
    a_alone_map: assert property (p_alone_map) else $error("stand-alone mapping wrong");

    property p_pair_a_quiet;
        @(posedge CLK) disable iff (RST)
        (state_reg == ST_RUN && role_reg == LVL_LOW && step_reg > 4'h6) |-> !mux_reg.drive;
    endproperty
    a_pair_a_quiet: assert property (p_pair_a_quiet) else $error("device A drove late step");

    property p_pair_b_map;
        @(posedge CLK) disable iff (RST)
        (state_reg == ST_RUN && role_reg == LVL_HIGH)
        |-> (mux_reg.drive == (step_reg > 4'h6))
            && (!mux_reg.drive || {1'b0, mux_reg.channel, mux_reg.shunt} == step_reg - 4'h7);
    endproperty
    a_pair_b_map: assert property (p_pair_b_map) else $error("device B mapping wrong");

    property p_wrap;
        @(posedge CLK) disable iff (RST)
        (state_reg == ST_RUN && step_rise && !timeout && en_full && step_reg == 4'hc)
        |=> (state_reg == ST_RUN && step_reg == 4'h1);
    endproperty
    a_wrap: assert property (p_wrap) else $error("sequence did not wrap");

    property p_timeout;
        @(posedge CLK) disable iff (RST)
        (state_reg == ST_RUN && !step_rise && !step_fall) [*8] ##1 (idle_cnt_reg == RESET_CYC)
        |=> (state_reg == ST_STANDBY) ##1 !mux_reg.drive;
    endproperty
    a_timeout: assert property (p_timeout) else $error("idle timeout ignored");

    property p_bus_invalid;
        @(posedge CLK) disable iff (RST)
        (s_check && !(&s_above)) |=> BUS_VALID_FLAG_OE;
    endproperty
    a_bus_invalid: assert property (p_bus_invalid) else $error("flag released too early");

    property p_no_supply;
        @(posedge CLK) disable iff (RST)
        (!s_sup) |=> BUS_VALID_FLAG_OE;
    endproperty
    a_no_supply: assert property (p_no_supply) else $error("flag released without supply");

    property p_ground_open;
        @(posedge CLK) disable iff (RST)
        (s_en == LVL_HIGH) |=> !DIVIDER_GROUND_SWITCH;
    endproperty
    a_ground_open: assert property (p_ground_open) else $error("ground switch closed");

    property p_disabled;
        @(posedge CLK) disable iff (RST)
        (s_en != LVL_LOW) |=> (state_reg == ST_STANDBY && step_reg == 4'h0 && !mux_reg.drive);
    endproperty
    a_disabled: assert property (p_disabled) else $error("step logic not held off");

    property p_restart;
        @(posedge CLK) disable iff (RST)
        (state_reg != ST_RUN) ##1 (state_reg == ST_RUN)
        |-> (step_reg == 4'h1 && $past(state_reg) == ST_GAP);
    endproperty
    a_restart: assert property (p_restart) else $error("run entered without arming");

endmodule

`default_nettype wire

//--- hw/pin_sync.sv
/*
 * Two-flip-flop synchroniser, one lane per input bit.
 * Assumes the inputs are asynchronous levels that change slowly against CLK.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,    // System clock.
    input  wire logic             rst,    // Asynchronous reset, active high.
    input  wire logic [WIDTH-1:0] d_in,   // Asynchronous levels.
    output logic      [WIDTH-1:0] q_out   // Synchronised levels.
);

    logic [WIDTH-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_lane
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_reg[i] <= 1'b0;
                    q_out[i]    <= 1'b0;
                end else begin
                    meta_reg[i] <= d_in[i];
                    q_out[i]    <= meta_reg[i];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire
